// ===== hdl/bpc_control.sv
// Purpose: basic control register and its effects for one internal phy
// Assumes: management access is a single-cycle read or write strobe
// Notes: straps are sampled by the loader, never under async reset
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - 16-bit control register at index zero
// - bit15 restores defaults, self clears
// - bit14 loops fabric transmit back to fabric
// - bit13 forces 10 or 100 Mbps
// - bit12 enables negotiation, overrides forced bits
// - bit11 enters general power down
// - negotiation after power down sets complete flag
// - bit9 restarts negotiation, self clears
// - bit8 forces half or full duplex
// - bit7 asserts collision while transmitting
// - speed default is negotiation OR speed strap
// - negotiation default equals negotiation strap
// - duplex default is NOT negotiation AND duplex
// - loader rewrites register after reset, reload
// - reached only by indexed management access
// - status bit5 shows negotiation complete
module bpc_control #(
   parameter int unsigned AN_CYCLES = bpc_pkg::AN_CYCLES
) (
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire logic STRAP_AUTONEG,
   input wire logic STRAP_SPEED,
   input wire logic STRAP_DUPLEX,
   input wire logic RELOAD,
   input wire logic MGMT_WR,
   input wire logic MGMT_RD,
   input wire logic [4:0] MGMT_IDX,
   input wire logic [15:0] MGMT_WDATA,
   output logic [15:0] MGMT_RDATA,
   input wire logic FABRIC_TX_EN,
   output logic LINE_TX_EN,
   output logic FABRIC_RX_LOOP,
   output logic COL,
   output logic SPEED_100,
   output logic FULL_DUPLEX,
   output logic POWER_DOWN,
   output logic AN_COMPLETE
);
   logic loopback;
   logic speed;
   logic an_en;
   logic pwr_down;
   logic duplex;
   logic col_test;
   logic an_done;
   logic load_pend;
   logic an_restart_pulse;
   logic an_finish;
   bpc_pkg::bpc_an_t an_state;
   bpc_pkg::bpc_an_t next_an_state;
   logic [15:0] ctrl_view;
   logic [15:0] status_view;

   // register reached only by index over management access
   wire wr_ctrl = MGMT_WR
      && (MGMT_IDX == bpc_pkg::IDX_CONTROL);
   wire rd_ctrl = MGMT_IDX == bpc_pkg::IDX_CONTROL;
   wire rd_stat = MGMT_IDX == bpc_pkg::IDX_STATUS;
   wire [15:0] wd = MGMT_WDATA & bpc_pkg::CTRL_RW_MASK;
   wire soft_rst = wr_ctrl && MGMT_WDATA[bpc_pkg::BIT_SOFT_RESET];
   // restart bit is outside the stored mask, so read it from raw data
   wire restart_wr = wr_ctrl && MGMT_WDATA[bpc_pkg::BIT_AN_RESTART];
   // loader defaults derived from straps
   wire def_speed = STRAP_AUTONEG | STRAP_SPEED;
   wire def_an = STRAP_AUTONEG;
   wire def_duplex = ~STRAP_AUTONEG & STRAP_DUPLEX;
   // straps captured one clock after release, never under reset
   wire do_load = load_pend || RELOAD || soft_rst;

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         load_pend <= 1'b1;
      end else begin
         load_pend <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         loopback <= 1'b0;
         speed <= 1'b0;
         an_en <= 1'b0;
         pwr_down <= 1'b0;
         duplex <= 1'b0;
         col_test <= 1'b0;
      end else if (do_load) begin
         loopback <= 1'b0;
         speed <= def_speed;
         an_en <= def_an;
         pwr_down <= 1'b0;
         duplex <= def_duplex;
         col_test <= 1'b0;
      end else if (wr_ctrl) begin
         loopback <= wd[bpc_pkg::BIT_LOOPBACK];
         speed <= wd[bpc_pkg::BIT_SPEED];
         an_en <= wd[bpc_pkg::BIT_AN_EN];
         pwr_down <= wd[bpc_pkg::BIT_PWR_DOWN];
         duplex <= wd[bpc_pkg::BIT_DUPLEX];
         col_test <= wd[bpc_pkg::BIT_COL_TEST];
      end
   end

   // negotiation restarts on enable, restart bit, or leaving power down;
   // judged on the written values so the old state cannot mask a kick
   wire new_an_en = wd[bpc_pkg::BIT_AN_EN];
   wire new_pwr_down = wd[bpc_pkg::BIT_PWR_DOWN];
   wire pd_fall = pwr_down && !new_pwr_down;
   wire an_rise = !an_en && new_an_en;
   wire wr_kick = wr_ctrl && !do_load && new_an_en && !new_pwr_down
      && (restart_wr || pd_fall || an_rise);
   // every load leaves power down clear, so the strap alone decides
   wire load_kick = do_load && def_an;
   assign an_restart_pulse = wr_kick || load_kick;
   wire an_hold = pwr_down || !an_en;

   bpc_an_timer #(.CYCLES(AN_CYCLES)) u_timer (
      .clk(MCLK),
      .arst_n(ARST_N),
      .start(an_restart_pulse),
      .hold(an_hold && !an_restart_pulse),
      .done(an_finish)
   );

   always_comb begin
      next_an_state = an_state;
      case (an_state)
         bpc_pkg::BPC_AN_IDLE: begin
            if (an_restart_pulse) next_an_state = bpc_pkg::BPC_AN_RUN;
         end
         bpc_pkg::BPC_AN_RUN: begin
            if (an_restart_pulse) next_an_state = bpc_pkg::BPC_AN_RUN;
            else if (an_hold) next_an_state = bpc_pkg::BPC_AN_IDLE;
            else if (an_finish) next_an_state = bpc_pkg::BPC_AN_DONE;
         end
         bpc_pkg::BPC_AN_DONE: begin
            if (an_restart_pulse) next_an_state = bpc_pkg::BPC_AN_RUN;
            else if (an_hold) next_an_state = bpc_pkg::BPC_AN_IDLE;
         end
         default: next_an_state = bpc_pkg::BPC_AN_IDLE;
      endcase
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         an_state <= bpc_pkg::BPC_AN_IDLE;
      end else begin
         an_state <= next_an_state;
      end
   end
   assign an_done = an_state == bpc_pkg::BPC_AN_DONE;

   // self-clearing bits and reserved bits always read zero
   always_comb begin
      ctrl_view = bpc_pkg::ZERO16;
      ctrl_view[bpc_pkg::BIT_LOOPBACK] = loopback;
      ctrl_view[bpc_pkg::BIT_SPEED] = speed;
      ctrl_view[bpc_pkg::BIT_AN_EN] = an_en;
      ctrl_view[bpc_pkg::BIT_PWR_DOWN] = pwr_down;
      ctrl_view[bpc_pkg::BIT_DUPLEX] = duplex;
      ctrl_view[bpc_pkg::BIT_COL_TEST] = col_test;
      status_view = bpc_pkg::STATUS_FIXED;
      status_view[bpc_pkg::BIT_AN_DONE] = an_done;
   end
   wire [15:0] rd_mux = rd_ctrl ? ctrl_view
      : (rd_stat ? status_view : bpc_pkg::ZERO16);

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         MGMT_RDATA <= bpc_pkg::ZERO16;
      end else if (MGMT_RD) begin
         MGMT_RDATA <= rd_mux;
      end
   end

   // link effects; forced bits matter only with negotiation off
   // limitation: negotiated result is modelled as best ability
   wire eff_speed = an_en ? 1'b1 : speed;
   wire eff_duplex = an_en ? 1'b1 : duplex;
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         SPEED_100 <= 1'b0;
         FULL_DUPLEX <= 1'b0;
      end else begin
         SPEED_100 <= eff_speed;
         FULL_DUPLEX <= eff_duplex;
      end
   end
   assign POWER_DOWN = pwr_down;
   assign AN_COMPLETE = an_done;
   assign LINE_TX_EN = FABRIC_TX_EN && !loopback && !pwr_down;
   assign FABRIC_RX_LOOP = FABRIC_TX_EN && loopback;
   assign COL = FABRIC_TX_EN && col_test;

   property p_restart_reads_zero;
      @(posedge MCLK) disable iff (!ARST_N)
      MGMT_RD && rd_ctrl |=> !MGMT_RDATA[bpc_pkg::BIT_AN_RESTART]
         && !MGMT_RDATA[bpc_pkg::BIT_SOFT_RESET];
   endproperty
   a_restart_reads_zero: assert property (p_restart_reads_zero)
      else $error("self clearing bit read as one");
   property p_soft_reset;
      @(posedge MCLK) disable iff (!ARST_N)
      soft_rst |=> !loopback && !col_test && !pwr_down
         && an_en == $past(def_an);
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("soft reset did not restore defaults");
   property p_loop;
      @(posedge MCLK) disable iff (!ARST_N)
      loopback && FABRIC_TX_EN |-> FABRIC_RX_LOOP && !LINE_TX_EN;
   endproperty
   a_loop: assert property (p_loop)
      else $error("loopback leaked to line");
   property p_forced_speed;
      @(posedge MCLK) disable iff (!ARST_N)
      !an_en |=> SPEED_100 == $past(speed) && FULL_DUPLEX == $past(duplex);
   endproperty
   a_forced_speed: assert property (p_forced_speed)
      else $error("forced speed or duplex not applied");
   property p_an_override;
      @(posedge MCLK) disable iff (!ARST_N)
      an_en |=> SPEED_100 && FULL_DUPLEX;
   endproperty
   a_an_override: assert property (p_an_override)
      else $error("forced bits affected link under negotiation");
   property p_col;
      @(posedge MCLK) disable iff (!ARST_N)
      col_test && FABRIC_TX_EN |-> COL;
   endproperty
   a_col: assert property (p_col)
      else $error("collision test missing");
   property p_reload;
      @(posedge MCLK) disable iff (!ARST_N)
      RELOAD |=> speed == $past(def_speed) && duplex == $past(def_duplex);
   endproperty
   a_reload: assert property (p_reload)
      else $error("reload did not rewrite register");
   property p_reserved;
      @(posedge MCLK) disable iff (!ARST_N)
      MGMT_RD && rd_ctrl |=> (MGMT_RDATA & ~bpc_pkg::CTRL_RW_MASK) == 16'h0000;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bit read as one");
   property p_status;
      @(posedge MCLK) disable iff (!ARST_N)
      MGMT_RD && rd_stat
         |=> MGMT_RDATA[bpc_pkg::BIT_AN_DONE] == $past(an_done);
   endproperty
   a_status: assert property (p_status)
      else $error("status complete bit wrong");
   property p_pd_no_an;
      @(posedge MCLK) disable iff (!ARST_N)
      pwr_down |=> !AN_COMPLETE;
   endproperty
   a_pd_no_an: assert property (p_pd_no_an)
      else $error("negotiation complete during power down");
   // multi-step checks: a restart-bit write must start a run, a quiet run that finishes must report complete
   sequence s_restart_write;
      wr_ctrl && !do_load && restart_wr && new_an_en && !new_pwr_down;
   endsequence
   sequence s_run_started;
      an_state == bpc_pkg::BPC_AN_RUN && !AN_COMPLETE;
   endsequence
   property p_restart_runs;
      @(posedge MCLK) disable iff (!ARST_N)
      s_restart_write |=> s_run_started;
   endproperty
   a_restart_runs: assert property (p_restart_runs)
      else $error("restart bit did not restart negotiation");
   sequence s_run_quiet_end;
      an_state == bpc_pkg::BPC_AN_RUN && an_finish
         && !an_hold && !an_restart_pulse;
   endsequence
   property p_an_finish;
      @(posedge MCLK) disable iff (!ARST_N)
      s_run_quiet_end |=> AN_COMPLETE;
   endproperty
   a_an_finish: assert property (p_an_finish)
      else $error("finished negotiation not reported");
   // the load edge is the one where the pending flag drops
   sequence s_load_done;
      load_pend ##1 !load_pend;
   endsequence
   property p_load_defaults;
      @(posedge MCLK) disable iff (!ARST_N)
      s_load_done |-> speed == $past(def_speed) && an_en == $past(def_an)
         && duplex == $past(def_duplex);
   endproperty
   a_load_defaults: assert property (p_load_defaults)
      else $error("strap defaults not loaded after reset");
   property p_pd_line;
      @(posedge MCLK) disable iff (!ARST_N)
      pwr_down |-> !LINE_TX_EN;
   endproperty
   a_pd_line: assert property (p_pd_line)
      else $error("line transmit active in power down");
   property p_an_off_incomplete;
      @(posedge MCLK) disable iff (!ARST_N)
      !an_en |=> !AN_COMPLETE;
   endproperty
   a_an_off_incomplete: assert property (p_an_off_incomplete)
      else $error("negotiation complete while disabled");
endmodule : bpc_control
`default_nettype wire

// ===== pkg/bpc_pkg.sv
// Purpose: constants for the basic phy control register block
// Assumes: 16-bit management register access, one clock
// Notes: bit positions follow the management register layout
package bpc_pkg;
   localparam int unsigned REG_W = 16;
   localparam int unsigned IDX_W = 5;
   localparam logic [4:0] IDX_CONTROL = 5'h00;
   localparam logic [4:0] IDX_STATUS = 5'h01;
   localparam int unsigned BIT_SOFT_RESET = 15;
   localparam int unsigned BIT_LOOPBACK = 14;
   localparam int unsigned BIT_SPEED = 13;
   localparam int unsigned BIT_AN_EN = 12;
   localparam int unsigned BIT_PWR_DOWN = 11;
   localparam int unsigned BIT_AN_RESTART = 9;
   localparam int unsigned BIT_DUPLEX = 8;
   localparam int unsigned BIT_COL_TEST = 7;
   localparam int unsigned BIT_AN_DONE = 5;
   localparam logic [15:0] CTRL_RW_MASK = 16'h7980;
   localparam logic [15:0] STATUS_FIXED = 16'h7809;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam int unsigned AN_TIME_US = 1000;
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned AN_CYCLES = AN_TIME_US * CLK_MHZ;
   typedef enum logic [1:0] {BPC_AN_IDLE, BPC_AN_RUN, BPC_AN_DONE} bpc_an_t;
endpackage : bpc_pkg

// ===== hdl/bpc_an_timer.sv
// Purpose: negotiation duration counter for one phy port
// Assumes: start pulses restart the count from zero
// Notes: the count stands in for the real link partner exchange
`timescale 1ns/1ps
`default_nettype none
module bpc_an_timer #(
   parameter int unsigned CYCLES = 16
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic start,
   input wire logic hold,
   output logic done
);
   localparam int unsigned CW = $clog2(CYCLES + 1);
   logic [CW-1:0] count;
   logic running;
   wire at_end = (count == CW'(CYCLES - 1));
   // elaboration check: a zero count would never raise done
   if (CYCLES < 1) begin : g_bad_cycles
      $error("timer needs at least one cycle");
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= '0;
         running <= 1'b0;
      end else if (start || hold) begin
         count <= '0;
         running <= start && !hold;
      end else if (running) begin
         count <= at_end ? '0 : count + CW'(1);
         running <= !at_end;
      end
   end
   assign done = running && at_end;
endmodule : bpc_an_timer
`default_nettype wire

// ===== verif/bpc_mgmt_master.sv
// Purpose: management master model driving the control register port
// Assumes: single-cycle strobes, read data valid one cycle after strobe
// Notes: released lines show inverted values so stale data is not trusted
`timescale 1ns/1ps
`default_nettype none
module bpc_mgmt_master (
   input wire logic clk,
   output logic wr,
   output logic rd,
   output logic [4:0] idx,
   output logic [15:0] wdata,
   input wire logic [15:0] rdata
);
   initial begin
      wr = 1'b0;
      rd = 1'b0;
      idx = 5'h1f;
      wdata = 16'h0000;
   end
   // one write strobe, then the bus is released
   task automatic put(input logic [4:0] i, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      idx <= i;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      idx <= ~i;
      wdata <= ~d;
   endtask : put
   // read data lands on the same edge that takes the strobe
   task automatic get(input logic [4:0] i, output logic [15:0] d);
      @(posedge clk);
      rd <= 1'b1;
      idx <= i;
      @(posedge clk);
      rd <= 1'b0;
      idx <= ~i;
      #1 d = rdata;
   endtask : get
endmodule : bpc_mgmt_master
`default_nettype wire

// ===== verif/tb_top.sv
// Purpose: self-checking bench for the basic phy control register
// Assumes: short negotiation count of 8 cycles
// Notes: expectations come from the strap and bit model below
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, s) begin num_checks++; if ((a) !== (b)) begin fails++; \
   $display("CHECK FAILED t=%0t %s", $time, s); end end
module tb_top;
   logic mclk, arst_n, s_an, s_spd, s_dup, reload, ftx, wr, rd;
   logic ltx, floop, col, spd, fdx, pd, anc;
   logic [4:0] idx;
   logic [15:0] wd, rdat, d, m;
   logic [31:0] seed;
   int fails, num_checks;
   bpc_control #(.AN_CYCLES(8)) dut (.MCLK(mclk), .ARST_N(arst_n),
      .STRAP_AUTONEG(s_an), .STRAP_SPEED(s_spd), .STRAP_DUPLEX(s_dup),
      .RELOAD(reload), .MGMT_WR(wr), .MGMT_RD(rd), .MGMT_IDX(idx),
      .MGMT_WDATA(wd), .MGMT_RDATA(rdat), .FABRIC_TX_EN(ftx),
      .LINE_TX_EN(ltx), .FABRIC_RX_LOOP(floop), .COL(col),
      .SPEED_100(spd), .FULL_DUPLEX(fdx), .POWER_DOWN(pd),
      .AN_COMPLETE(anc));
   bpc_mgmt_master mm (.clk(mclk), .wr(wr), .rd(rd), .idx(idx),
      .wdata(wd), .rdata(rdat));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [15:0] dflt();
      return {2'b00, s_an | s_spd, s_an, 3'b000, ~s_an & s_dup, 8'h00};
   endfunction : dflt
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   task automatic do_reset();
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (2) @(posedge mclk);
   endtask : do_reset
   // forced link settings only hold while negotiation is off
   task automatic chk_out();
      `CHK(pd, m[11], "power down")
      `CHK(ltx, ftx & ~m[14] & ~m[11], "line tx")
      if (!m[11]) begin
         `CHK(floop, ftx & m[14], "loop rx")
         `CHK(col, ftx & m[7], "collision")
      end
      if (!m[12]) begin
         `CHK(spd, m[13], "speed")
         `CHK(fdx, m[8], "duplex")
      end else begin
         `CHK(spd, 1'b1, "negotiated speed")
         `CHK(fdx, 1'b1, "negotiated duplex")
      end
   endtask : chk_out
   task automatic wait_an();
      for (int w = 0; w < 30 && anc !== 1'b1; w++) @(posedge mclk);
      #1 `CHK(anc, 1'b1, "an done")
   endtask : wait_an
   initial begin
      {s_an, s_spd, s_dup, reload, ftx} = 5'h00;
      arst_n = 1'b0;
      seed = 32'h000113cc;
      fails = 0;
      num_checks = 0;
      for (int k = 0; k < 8; k++) begin
         {s_an, s_spd, s_dup} <= 3'(k);
         do_reset();
         mm.get(5'h00, d);
         `CHK(d, dflt(), "strap default")
      end
      $display("test defaults done");
      for (int k = 0; k < 16; k++) begin
         seed = lfsr(seed);
         m = seed[15:0] & 16'h7fff;
         if (m[12]) m[11] = 1'b0;
         if (m[7]) m[14] = 1'b1;
         // no mac here to receive own transmit, so loop only full duplex
         if (m[14]) m[8] = 1'b1;
         @(posedge mclk);
         ftx <= seed[16];
         mm.put(5'h00, m);
         mm.get(5'h00, d);
         m = m & bpc_pkg::CTRL_RW_MASK;
         `CHK(d, m, "readback")
         chk_out();
      end
      $display("test random access done");
      mm.put(5'h00, 16'h0000);
      mm.put(5'h00, 16'h0800);
      mm.get(5'h01, d);
      `CHK(d, bpc_pkg::STATUS_FIXED, "pd status")
      `CHK(anc, 1'b0, "pd clears an")
      mm.put(5'h00, 16'h1000);
      wait_an();
      mm.get(5'h01, d);
      `CHK(d, bpc_pkg::STATUS_FIXED | 16'h0020, "an status")
      mm.put(5'h00, 16'h1200);
      #1 `CHK(anc, 1'b0, "restart reruns")
      mm.get(5'h00, d);
      `CHK(d, 16'h1000, "restart clears")
      wait_an();
      mm.put(5'h03, 16'hffff);
      mm.get(5'h03, d);
      `CHK(d, 16'h0000, "other index")
      $display("test negotiation done");
      mm.put(5'h00, 16'h4180);
      mm.put(5'h00, 16'h8000);
      mm.get(5'h00, d);
      `CHK(d, dflt(), "soft reset")
      mm.put(5'h00, 16'h0180);
      @(posedge mclk);
      {s_an, s_spd, s_dup} <= 3'b011;
      reload <= 1'b1;
      @(posedge mclk);
      reload <= 1'b0;
      mm.get(5'h00, d);
      `CHK(d, dflt(), "reload")
      $display("test reset and reload done");
      tally_and_finish();
   end
   // whole run is a few hundred cycles
   initial begin
      #100us;
      fails++;
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
